// File: core/irq_ctrl.sv
// Interrupt enable and flag logic with an Avalon-MM register slave.
// Assumes inputs synchronous to core_clk; event inputs are one-cycle
// pulses, port pins are levels.
//
// Summary of operation
// - global enable gates every interrupt to core
// - peripheral enable gates all peripheral interrupts to core
// - second enable sources need peripheral enable
// - flags set regardless of any enable but the per-pin change enables
// - timer overflow flag sticky until software clear
// - timer overflow enable passes its flag
// - external pin enable passes its flag
// - external pin flag sticky until cleared
// - port change needs per-pin enables too
// - port change flag set on pin change
// - core control register fully read/write
// - bit 7 enables oscillator fail interrupt
// - bits 6,5 enable comparator two, one
// - bit 4 enables LCD interrupt
// - bit 2 enables low voltage interrupt
// - bit 0 enables capture/compare two
`timescale 1ns/1ps

module irq_ctrl
    import irq_ctrl_pkg::*;
#(
    parameter int PORT_WIDTH = 4,
    parameter bit HAS_CCP2 = 1'b1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt sources
    input wire logic timer_rollover,
    input wire logic ext_pin_event,
    input wire logic [PORT_WIDTH-1:0] port_pins,
    input wire logic [PORT_WIDTH-1:0] per_pin_change_enables,
    input wire logic osc_fail_event,
    input wire logic comparator_two_event,
    input wire logic comparator_one_event,
    input wire logic lcd_event,
    input wire logic low_voltage_event,
    input wire logic capcomp_two_event,
    // Interrupt outputs
    output logic core_irq,
    output logic status_irq
);

    typedef struct packed {
        logic global_irq_enable;
        logic periph_irq_enable;
        logic timer_ovf_irq_enable;
        logic ext_pin_irq_enable;
        logic port_change_irq_enable;
        logic timer_ovf_flag;
        logic ext_pin_flag;
        logic port_change_flag;
        logic [7:0] enable_two;
        logic [7:0] pflag;
        logic [7:0] pmask;
        logic [PORT_WIDTH-1:0] pins_last;
        logic [31:0] rdata;
        logic waitreq;
        logic core_irq;
        logic status_irq;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic [7:0] ctrl_val;
    logic [7:0] enable_two_val;
    logic [7:0] pev;
    logic [7:0] enable_two_wmask;
    logic [3:0] sel;
    logic pin_changed;
    logic wr_ctrl;
    logic wr_enable_two;
    logic wr_pmask;
    logic rd_pflag;
    logic req;
    logic core_req;

    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h0000_00, v};
    endfunction

    // One-hot register select from the byte address
    function automatic logic [3:0] reg_select(input logic [3:0] a);
        reg_select = 4'h0;
        if (a == CTRL_OFFSET) begin
            reg_select = 4'h1;
        end else if (a == ENABLE_TWO_OFFSET) begin
            reg_select = 4'h2;
        end else if (a == PFLAG_OFFSET) begin
            reg_select = 4'h4;
        end else if (a == PMASK_OFFSET) begin
            reg_select = 4'h8;
        end
    endfunction

    assign ctrl_val = {st_r.global_irq_enable, st_r.periph_irq_enable,
        st_r.timer_ovf_irq_enable, st_r.ext_pin_irq_enable,
        st_r.port_change_irq_enable, st_r.timer_ovf_flag,
        st_r.ext_pin_flag, st_r.port_change_flag};
    assign enable_two_wmask = HAS_CCP2 ? ENABLE_TWO_IMPL_MASK
        : (ENABLE_TWO_IMPL_MASK & ~CCP2_MASK);
    assign enable_two_val = st_r.enable_two & enable_two_wmask;

    // Peripheral event vector, laid out like the enable register two
    always_comb begin
        pev = 8'h00;
        pev[OSCF_BIT] = osc_fail_event;
        pev[CMP2_BIT] = comparator_two_event;
        pev[CMP1_BIT] = comparator_one_event;
        pev[LCD_BIT] = lcd_event;
        pev[LVD_BIT] = low_voltage_event;
        pev[CCP2_BIT] = capcomp_two_event & HAS_CCP2;
    end

    assign pin_changed = |((port_pins ^ st_r.pins_last)
        & per_pin_change_enables);

    // One wait cycle: a request is answered on the cycle after it appears
    assign req = (avs_read | avs_write) & st_r.waitreq;
    assign sel = reg_select(avs_address);
    assign wr_ctrl = req & avs_write & avs_byteenable[0]
        & sel[0];
    assign wr_enable_two = req & avs_write & avs_byteenable[0]
        & sel[1];
    assign wr_pmask = req & avs_write & avs_byteenable[0]
        & sel[3];
    assign rd_pflag = req & avs_read & sel[2];

    // Interrupt request to the core
    assign core_req = ctrl_val[GLOBAL_EN_BIT] & (
        (ctrl_val[TOVF_EN_BIT] & ctrl_val[TOVF_FLAG_BIT]) |
        (ctrl_val[EXT_EN_BIT] & ctrl_val[EXT_FLAG_BIT]) |
        (ctrl_val[PCHG_EN_BIT] & ctrl_val[PCHG_FLAG_BIT]) |
        (ctrl_val[PERIPH_EN_BIT]
            & |(enable_two_val & st_r.pflag)));

    always_comb begin
        st_nxt = st_r;
        st_nxt.waitreq = ~req;
        st_nxt.pins_last = port_pins;
        // Software writes first, hardware sets win afterwards
        if (wr_ctrl) begin
            {st_nxt.global_irq_enable, st_nxt.periph_irq_enable,
             st_nxt.timer_ovf_irq_enable, st_nxt.ext_pin_irq_enable,
             st_nxt.port_change_irq_enable, st_nxt.timer_ovf_flag,
             st_nxt.ext_pin_flag, st_nxt.port_change_flag}
                = avs_writedata[7:0];
        end
        if (wr_enable_two) begin
            st_nxt.enable_two = avs_writedata[7:0]
                & enable_two_wmask;
        end
        if (wr_pmask) begin
            st_nxt.pmask = avs_writedata[7:0];
        end
        if (rd_pflag) begin
            st_nxt.pflag = 8'h00;
        end
        if (timer_rollover) begin
            st_nxt.timer_ovf_flag = 1'b1;
        end
        if (ext_pin_event) begin
            st_nxt.ext_pin_flag = 1'b1;
        end
        if (pin_changed) begin
            st_nxt.port_change_flag = 1'b1;
        end
        st_nxt.pflag = st_nxt.pflag | pev;
        // Read data path
        st_nxt.rdata = 32'h0000_0000;
        if (req && avs_read) begin
            if (sel[0]) begin
                st_nxt.rdata = zext8(ctrl_val);
            end else if (sel[1]) begin
                st_nxt.rdata = zext8(enable_two_val);
            end else if (sel[2]) begin
                st_nxt.rdata = zext8(st_r.pflag);
            end else if (sel[3]) begin
                st_nxt.rdata = zext8(st_r.pmask);
            end else begin
                st_nxt.rdata = 32'h0000_0000;
            end
        end
        st_nxt.core_irq = core_req;
        st_nxt.status_irq = |(st_r.pflag & st_r.pmask);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.enable_two <= ENABLE_TWO_RESET;
            st_r.waitreq <= 1'b1;
            {st_r.global_irq_enable, st_r.periph_irq_enable,
             st_r.timer_ovf_irq_enable, st_r.ext_pin_irq_enable,
             st_r.port_change_irq_enable, st_r.timer_ovf_flag,
             st_r.ext_pin_flag, st_r.port_change_flag} <= CTRL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = st_r.waitreq;
    assign core_irq = st_r.core_irq;
    assign status_irq = st_r.status_irq;

    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_req_taken;
        (avs_read | avs_write) && avs_waitrequest;
    endsequence

    sequence s_answer;
        !avs_waitrequest;
    endsequence

    a_global_gate: assert property (
        !ctrl_val[GLOBAL_EN_BIT] |=> !core_irq)
        else $error("irq raised with global enable low");

    a_periph_gate: assert property (
        !ctrl_val[PERIPH_EN_BIT]
        && !(ctrl_val[TOVF_EN_BIT] && ctrl_val[TOVF_FLAG_BIT])
        && !(ctrl_val[EXT_EN_BIT] && ctrl_val[EXT_FLAG_BIT])
        && !(ctrl_val[PCHG_EN_BIT] && ctrl_val[PCHG_FLAG_BIT])
        |=> !core_irq)
        else $error("peripheral irq passed with peripheral enable low");

    a_two_needs_periph: assert property (
        (ctrl_val[7:3] == 5'b10000) |=> !core_irq)
        else $error("second enable source bypassed peripheral enable");

    a_timer_flag_set: assert property (
        timer_rollover |=> ctrl_val[TOVF_FLAG_BIT])
        else $error("timer overflow flag not set");

    a_timer_flag_hold: assert property (
        ctrl_val[TOVF_FLAG_BIT] && !wr_ctrl |=> ctrl_val[TOVF_FLAG_BIT])
        else $error("timer overflow flag cleared without write");

    a_ext_flag_set: assert property (
        ext_pin_event |=> ctrl_val[EXT_FLAG_BIT])
        else $error("external pin flag not set");

    a_port_flag_set: assert property (
        pin_changed |=> ctrl_val[PCHG_FLAG_BIT])
        else $error("port change flag not set");

    a_two_zero_bits: assert property (
        avs_read && (avs_address == ENABLE_TWO_OFFSET) && !avs_waitrequest
        |-> avs_readdata[3] == 1'b0 && avs_readdata[1] == 1'b0)
        else $error("unimplemented enable bits read nonzero");

    a_irq_equation: assert property (
        1'b1 |=> core_irq == $past(core_req))
        else $error("core irq does not follow enabled flags");

    a_ctrl_write: assert property (
        wr_ctrl && !timer_rollover && !ext_pin_event && !pin_changed
        |=> ctrl_val == $past(avs_writedata[7:0]))
        else $error("control register write lost");

    a_bus_answer: assert property (
        s_req_taken |=> s_answer)
        else $error("slave did not answer in one cycle");

    // Gating of each source and stickiness of each flag
    sequence s_periph_open;
        ctrl_val[GLOBAL_EN_BIT] && ctrl_val[PERIPH_EN_BIT];
    endsequence

    sequence s_periph_pending;
        s_periph_open ##0 (|(enable_two_val & st_r.pflag));
    endsequence

    a_timer_enable: assert property (
        ctrl_val[GLOBAL_EN_BIT] && ctrl_val[TOVF_EN_BIT]
        && ctrl_val[TOVF_FLAG_BIT] |=> core_irq)
        else $error("enabled timer overflow flag gave no irq");

    a_ext_enable: assert property (
        ctrl_val[GLOBAL_EN_BIT] && ctrl_val[EXT_EN_BIT]
        && ctrl_val[EXT_FLAG_BIT] |=> core_irq)
        else $error("enabled external pin flag gave no irq");

    a_port_enable: assert property (
        ctrl_val[GLOBAL_EN_BIT] && ctrl_val[PCHG_EN_BIT]
        && ctrl_val[PCHG_FLAG_BIT] |=> core_irq)
        else $error("enabled port change flag gave no irq");

    a_periph_pass: assert property (
        s_periph_pending |=> core_irq)
        else $error("enabled peripheral flag gave no irq");

    a_osc_fail_pass: assert property (
        s_periph_open ##0 (enable_two_val[OSCF_BIT]
        && st_r.pflag[OSCF_BIT]) |=> core_irq)
        else $error("oscillator fail irq not passed");

    a_cmp_two_pass: assert property (
        s_periph_open ##0 (enable_two_val[CMP2_BIT]
        && st_r.pflag[CMP2_BIT]) |=> core_irq)
        else $error("comparator two irq not passed");

    a_cmp_one_pass: assert property (
        s_periph_open ##0 (enable_two_val[CMP1_BIT]
        && st_r.pflag[CMP1_BIT]) |=> core_irq)
        else $error("comparator one irq not passed");

    a_lcd_pass: assert property (
        s_periph_open ##0 (enable_two_val[LCD_BIT]
        && st_r.pflag[LCD_BIT]) |=> core_irq)
        else $error("lcd irq not passed");

    a_low_volt_pass: assert property (
        s_periph_open ##0 (enable_two_val[LVD_BIT]
        && st_r.pflag[LVD_BIT]) |=> core_irq)
        else $error("low voltage irq not passed");

    a_capcomp_pass: assert property (
        s_periph_open ##0 (enable_two_val[CCP2_BIT]
        && st_r.pflag[CCP2_BIT]) |=> core_irq)
        else $error("capture compare two irq not passed");

    a_timer_flag_quiet: assert property (
        !timer_rollover && !wr_ctrl && !ctrl_val[TOVF_FLAG_BIT]
        |=> !ctrl_val[TOVF_FLAG_BIT])
        else $error("timer overflow flag set without rollover");

    a_ext_flag_hold: assert property (
        ctrl_val[EXT_FLAG_BIT] && !wr_ctrl |=> ctrl_val[EXT_FLAG_BIT])
        else $error("external pin flag cleared without write");

    a_ext_flag_quiet: assert property (
        !ext_pin_event && !wr_ctrl && !ctrl_val[EXT_FLAG_BIT]
        |=> !ctrl_val[EXT_FLAG_BIT])
        else $error("external pin flag set without event");

    a_port_flag_hold: assert property (
        ctrl_val[PCHG_FLAG_BIT] && !wr_ctrl |=> ctrl_val[PCHG_FLAG_BIT])
        else $error("port change flag cleared without write");

    a_port_flag_quiet: assert property (
        !pin_changed && !wr_ctrl && !ctrl_val[PCHG_FLAG_BIT]
        |=> !ctrl_val[PCHG_FLAG_BIT])
        else $error("port change flag set without a pin change");

    a_periph_flag_set: assert property (
        pev != 8'h00 |=> (st_r.pflag & $past(pev)) == $past(pev))
        else $error("peripheral status bit not set on event");

    a_status_sticky: assert property (
        st_r.pflag != 8'h00 && !rd_pflag
        |=> (st_r.pflag & $past(st_r.pflag)) == $past(st_r.pflag))
        else $error("status bit dropped without a read");

    a_two_write: assert property (
        wr_enable_two |=> enable_two_val
        == ($past(avs_writedata[7:0]) & enable_two_wmask))
        else $error("enable two write lost");

    a_status_level: assert property (
        |(st_r.pflag & st_r.pmask) |=> status_irq)
        else $error("masked status bit gave no status irq");

    a_wait_one_cycle: assert property (
        s_answer |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

endmodule // irq_ctrl

// File: inc/irq_ctrl_pkg.sv
// Package for the interrupt enable and flag logic.
// Assumes an Avalon-MM slave with 32-bit data, word-aligned registers.
package irq_ctrl_pkg;

    // Register byte offsets
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] ENABLE_TWO_OFFSET = 4'h4;
    localparam logic [3:0] PFLAG_OFFSET = 4'h8;
    localparam logic [3:0] PMASK_OFFSET = 4'hC;

    // Core interrupt control field positions
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PERIPH_EN_BIT = 6;
    localparam int TOVF_EN_BIT = 5;
    localparam int EXT_EN_BIT = 4;
    localparam int PCHG_EN_BIT = 3;
    localparam int TOVF_FLAG_BIT = 2;
    localparam int EXT_FLAG_BIT = 1;
    localparam int PCHG_FLAG_BIT = 0;

    // Peripheral enable two field positions
    localparam int OSCF_BIT = 7;
    localparam int CMP2_BIT = 6;
    localparam int CMP1_BIT = 5;
    localparam int LCD_BIT = 4;
    localparam int LVD_BIT = 2;
    localparam int CCP2_BIT = 0;

    // Writable bits of peripheral enable two (bits 3 and 1 absent)
    localparam logic [7:0] ENABLE_TWO_IMPL_MASK = 8'hF5;
    localparam logic [7:0] CCP2_MASK = 8'h01;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ENABLE_TWO_RESET = 8'h00;

    // Answer latency of the slave in cycles
    localparam int ANSWER_CYCLES = 1;

endpackage : irq_ctrl_pkg

// File: sim/irq_ctrl_tb.sv
// Self-checking bench for the interrupt enable and flag logic.
// Drives the Avalon-MM slave and all event inputs; read results are
// expected by the driver in a queue and compared by a separate monitor process.
`timescale 1ns/1ps

module irq_ctrl_tb import irq_ctrl_pkg::*; ;
    logic core_clk, resetn, avs_read, avs_write, t_ev, x_ev;
    logic [3:0] avs_address, avs_byteenable, pins, ppe;
    logic [31:0] avs_writedata, avs_readdata, rng;
    logic avs_waitrequest, core_irq, status_irq;
    logic [7:0] pev, b, v;
    logic [31:0] exp_q[$];
    int bad_count, comparisons, cyc;
    int bits[6] = '{7, 6, 5, 4, 2, 0};

    irq_ctrl i_irq_ctrl (.core_clk(core_clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer_rollover(t_ev),
        .ext_pin_event(x_ev), .port_pins(pins),
        .per_pin_change_enables(ppe), .osc_fail_event(pev[7]),
        .comparator_two_event(pev[6]), .comparator_one_event(pev[5]),
        .lcd_event(pev[4]), .low_voltage_event(pev[2]),
        .capcomp_two_event(pev[0]), .core_irq(core_irq),
        .status_irq(status_irq));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic fail(input string m);
        bad_count++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] e,
                       input string m);
        comparisons++;
        if (got !== e) fail(m);
    endtask

    task automatic end_of_test();
        $display("counts: %0d comparisons, %0d mismatches", comparisons,
                 bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d, input logic [3:0] be);
        int n;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) fail("no answer on bus");
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back({24'h00_0000, e});
        bus(1'b0, a, 8'h00, 4'hF);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic pulse(input logic [7:0] p, input logic t,
                         input logic x, input logic [3:0] pc);
        @(posedge core_clk);
        pev <= p;
        t_ev <= t;
        x_ev <= x;
        pins <= pins ^ pc;
        @(posedge core_clk);
        pev <= 8'h00;
        t_ev <= 1'b0;
        x_ev <= 1'b0;
    endtask

    task automatic irq(input logic ec, input logic es);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk({31'h0, core_irq}, {31'h0, ec}, "core_irq level");
        chk({31'h0, status_irq}, {31'h0, es}, "status_irq level");
        @(posedge core_clk);
    endtask

    // Read data monitor: oldest queued note against the answer
    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            comparisons++;
            if (exp_q.size() == 0) fail("read without note");
            else if (avs_readdata !== exp_q.pop_front())
                fail("read data mismatch");
        end
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 5000) begin
            fail("timeout");
            end_of_test();
        end
    end

    initial begin
        rng = 32'h0000_002A;
        {resetn, avs_read, avs_write, t_ev, x_ev} = '0;
        {avs_address, avs_byteenable, pins, ppe, pev} = '0;
        avs_writedata = 32'h0000_0000;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        rd(CTRL_OFFSET, CTRL_RESET);
        rd(ENABLE_TWO_OFFSET, ENABLE_TWO_RESET);
        rd(PFLAG_OFFSET, 8'h00);
        rd(PMASK_OFFSET, 8'h00);
        rd(4'h2, 8'h00);
        irq(1'b0, 1'b0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            v = 8'(xs());
            wr(CTRL_OFFSET, v);
            rd(CTRL_OFFSET, v);
        end
        wr(CTRL_OFFSET, 8'h00);
        wr(ENABLE_TWO_OFFSET, 8'hFF);
        rd(ENABLE_TWO_OFFSET, ENABLE_TWO_IMPL_MASK);
        bus(1'b1, CTRL_OFFSET, 8'hFF, 4'h0);
        rd(CTRL_OFFSET, 8'h00);
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'h00);
        $display("test registers done");
        pulse(8'h00, 1'b0, 1'b0, 4'(xs()) | 4'h1);
        rd(CTRL_OFFSET, 8'h00);
        ppe <= 4'hF;
        pulse(8'h00, 1'b1, 1'b1, 4'(xs()) | 4'h1);
        repeat (5) @(posedge core_clk);
        rd(CTRL_OFFSET, 8'h07);
        irq(1'b0, 1'b0);
        wr(CTRL_OFFSET, 8'h00);
        rd(CTRL_OFFSET, 8'h00);
        $display("test sticky flags done");
        for (int i = 0; i < 3; i++) begin
            v = 8'h20 >> i;
            wr(CTRL_OFFSET, 8'h80 | v);
            pulse(8'h00, i == 0, i == 1, (i == 2) ? 4'h2 : 4'h0);
            irq(1'b1, 1'b0);
            wr(CTRL_OFFSET, v | (8'h04 >> i));
            irq(1'b0, 1'b0);
            wr(CTRL_OFFSET, 8'h80 | (8'h04 >> i));
            irq(1'b0, 1'b0);
            wr(CTRL_OFFSET, 8'h00);
        end
        $display("test core sources done");
        foreach (bits[k]) begin
            b = 8'h01 << bits[k];
            wr(ENABLE_TWO_OFFSET, b);
            wr(PMASK_OFFSET, b);
            wr(CTRL_OFFSET, 8'h80);
            pulse(b, 1'b0, 1'b0, 4'h0);
            irq(1'b0, 1'b1);
            wr(CTRL_OFFSET, 8'hC0);
            irq(1'b1, 1'b1);
            wr(ENABLE_TWO_OFFSET, 8'h00);
            irq(1'b0, 1'b1);
            rd(PFLAG_OFFSET, b);
            rd(PFLAG_OFFSET, 8'h00);
            irq(1'b0, 1'b0);
            wr(CTRL_OFFSET, 8'h00);
        end
        $display("test peripheral sources done");
        repeat (2) @(posedge core_clk);
        end_of_test();
    end
endmodule // irq_ctrl_tb
